// >>> tb.sv
/*
 Self-checking bench for the welder cycle handshake: horn model, AXI master.
 Assumes wch_plc_model on the start and reset lines and wch_regs.svh.
*/
`timescale 1ns/1ps
`include "wch_regs.svh"
module tb;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cycle_abort = 1'b0;
	logic        safety_halt = 1'b0;
	logic        fault = 1'b0;
	logic        upper_limit = 1'b1;
	logic [15:0] horn_pos = 16'h0000;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        start_a, start_b, ext_reset, ready_n, start_release_permit, general_alarm;
	logic        clear_out, horn_extend, irq, awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          failures = 0;
	int          check_count = 0;
	int          cyc = 0;

	wch_welder_handshake #(.CHECK_CYC(32'd200)) u_wch_welder_handshake (
		.sys_clk, .nrst, .start_a, .start_b, .ext_reset, .cycle_abort, .safety_halt, .fault,
		.upper_limit, .horn_pos, .ready_n, .start_release_permit, .general_alarm, .clear_out,
		.horn_extend, .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	wch_plc_model u_wch_plc_model (.sys_clk, .ready_n, .start_release_permit, .general_alarm,
		.start_a, .start_b, .ext_reset);

	// Clock
	always #2.5 sys_clk = ~sys_clk;

	// Horn travels down while extended, back up otherwise
	always @(posedge sys_clk) begin
		if (horn_extend === 1'b1) begin
			if (horn_pos < 16'h0200) horn_pos <= horn_pos + 16'h0010;
		end else if (horn_pos != 16'h0000) horn_pos <= horn_pos - 16'h0008;
		upper_limit <= (horn_pos == 16'h0000) && (horn_extend !== 1'b1);
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
	                      input logic [3:0] s = 4'hf);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Drive one machine line: 0 abort, 1 halt, else fault
	task automatic set_line(input int which, input logic v);
		case (which)
			0: cycle_abort <= v;
			1: safety_halt <= v;
			default: fault <= v;
		endcase
	endtask

	task automatic wait_ready(input int lim, output int n);
		n = 0;
		while (ready_n !== 1'b0 && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	task automatic wait_clear(input int lim);
		int n;
		n = 0;
		while (clear_out !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	// Reset values, unmapped place, short weld and hold times
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(`WCH_OFS_CTRL, d, r);
		cmp(d, `WCH_RST_CTRL);
		axi_rd(`WCH_OFS_CLEAR_DIST, d, r);
		cmp(d, `WCH_RST_CLEAR_DIST);
		axi_wr(`WCH_OFS_CLEAR_DIST, 32'hffff_ff20, r, 4'h1);
		axi_rd(`WCH_OFS_CLEAR_DIST, d, r);
		cmp(d, 32'h0000_0120);
		axi_rd(8'h40, d, r);
		cmp({30'h0, r}, 32'h2);
		axi_wr(8'h40, 32'h1, r);
		cmp({30'h0, r}, 32'h2);
		axi_wr(`WCH_OFS_WELD_TIME, 32'h14, r);
		axi_wr(`WCH_OFS_HOLD_TIME, 32'h14, r);
		axi_wr(`WCH_OFS_CTRL, 32'h6, r);
		axi_rd(`WCH_OFS_HOLD_TIME, d, r);
		cmp(d, 32'h14);
	endtask

	// One start refused with an actuator, both accepted, clearance before ready
	task automatic t_dual();
		logic ok;
		int   n;
		u_wch_plc_model.press(1'b0, 1'b0);
		u_wch_plc_model.await_permit(30, ok);
		cmp({31'h0, ok}, 32'h0);
		u_wch_plc_model.let_go(1);
		repeat (8) @(posedge sys_clk);
		u_wch_plc_model.press(1'b1, 1'b0);
		u_wch_plc_model.await_permit(30, ok);
		cmp({31'h0, ok}, 32'h1);
		u_wch_plc_model.let_go(2);
		wait_clear(300);
		cmp({31'h0, clear_out}, 32'h1);
		cmp({31'h0, ready_n}, 32'h1);
		wait_ready(300, n);
		cmp({31'h0, ready_n}, 32'h0);
	endtask

	// Start during abort is dropped, not queued, and raises the interrupt
	task automatic t_discard();
		logic        ok;
		logic [31:0] d;
		logic [1:0]  r;
		set_line(0, 1'b1);
		repeat (6) @(posedge sys_clk);
		cmp({31'h0, ready_n}, 32'h1);
		u_wch_plc_model.press(1'b1, 1'b1);
		u_wch_plc_model.await_permit(20, ok);
		cmp({31'h0, ok}, 32'h0);
		set_line(0, 1'b0);
		u_wch_plc_model.await_permit(40, ok);
		cmp({31'h0, ok}, 32'h0);
		u_wch_plc_model.let_go(1);
		axi_rd(`WCH_OFS_IRQ_STAT, d, r);
		cmp(d & 32'h10, 32'h10);
		axi_wr(`WCH_OFS_IRQ_MASK, 32'h10, r);
		repeat (3) @(posedge sys_clk);
		cmp({31'h0, irq}, 32'h1);
		axi_wr(`WCH_OFS_IRQ_STAT, 32'h10, r);
		repeat (3) @(posedge sys_clk);
		cmp({31'h0, irq}, 32'h0);
	endtask

	// Abort mid-weld retracts and returns quickly without reset
	task automatic t_abort();
		logic ok;
		int   n;
		u_wch_plc_model.press(1'b1, 1'b0);
		u_wch_plc_model.await_permit(30, ok);
		repeat (4) @(posedge sys_clk);
		set_line(0, 1'b1);
		repeat (10) @(posedge sys_clk);
		cmp({31'h0, horn_extend}, 32'h0);
		u_wch_plc_model.let_go(1);
		set_line(0, 1'b0);
		wait_ready(100, n);
		cmp({31'h0, ready_n}, 32'h0);
		cmp({31'h0, general_alarm}, 32'h0);
		cmp({31'h0, n < 100}, 32'h1);
	endtask

	// Reset without alarm, held reset, safety halt with check time
	task automatic t_halt();
		int n;
		u_wch_plc_model.pulse_reset();
		repeat (6) @(posedge sys_clk);
		cmp({31'h0, ready_n}, 32'h0);
		u_wch_plc_model.hold_reset(1'b1);
		set_line(2, 1'b1);
		repeat (10) @(posedge sys_clk);
		set_line(2, 1'b0);
		repeat (20) @(posedge sys_clk);
		cmp({31'h0, general_alarm}, 32'h1);
		u_wch_plc_model.hold_reset(1'b0);
		repeat (4) @(posedge sys_clk);
		u_wch_plc_model.pulse_reset();
		repeat (10) @(posedge sys_clk);
		cmp({31'h0, general_alarm}, 32'h0);
		set_line(1, 1'b1);
		repeat (10) @(posedge sys_clk);
		set_line(1, 1'b0);
		repeat (30) @(posedge sys_clk);
		cmp({31'h0, ready_n}, 32'h1);
		u_wch_plc_model.pulse_reset();
		wait_ready(400, n);
		cmp({31'h0, n > 150}, 32'h1);
		cmp({31'h0, ready_n}, 32'h0);
	endtask

	// Stack only: single start, clearance toggles on the upper limit
	task automatic t_stack();
		logic       ok;
		logic [1:0] r;
		axi_wr(`WCH_OFS_CTRL, 32'h3, r);
		u_wch_plc_model.press(1'b0, 1'b0);
		u_wch_plc_model.await_permit(30, ok);
		cmp({31'h0, ok}, 32'h1);
		u_wch_plc_model.let_go(2);
		wait_clear(300);
		cmp({31'h0, clear_out}, 32'h1);
	endtask

	task automatic end_sim();
		$display("Counts: %0d mismatches, %0d checks", failures, check_count);
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_regs();
		t_dual();
		t_discard();
		t_abort();
		t_halt();
		t_stack();
		end_sim();
	end
endmodule

// >>> wch_pkg.sv
/*
 Types for the welder cycle handshake block.
 Assumes the constants in wch_regs.svh.
*/
package wch_pkg;

	typedef enum logic [2:0] {
		WCH_ST_READY   = 3'h0,
		WCH_ST_WELD    = 3'h1,
		WCH_ST_HOLD    = 3'h2,
		WCH_ST_RETRACT = 3'h3,
		WCH_ST_HALT    = 3'h4,
		WCH_ST_CHECK   = 3'h5
	} wch_state_t;

	typedef logic [1:0] wch_resp_t;

endpackage

// >>> wch_plc_model.sv
/*
 Machine controller model driving the start and reset lines.
 Assumes calls are made right after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module wch_plc_model (
	input  wire logic sys_clk,
	input  wire logic ready_n,
	input  wire logic start_release_permit,
	input  wire logic general_alarm,
	output logic      start_a,
	output logic      start_b,
	output logic      ext_reset
);
	// Lines idle low
	initial begin
		start_a = 1'b0;
		start_b = 1'b0;
		ext_reset = 1'b0;
	end

	// Press start once ready shows, unless told to be rude
	task automatic press(input logic both, input logic rude);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!rude && ready_n !== 1'b0 && n < 2000);
		start_a <= 1'b1;
		start_b <= both;
	endtask

	// Hold start until permit; drop at once on alarm
	task automatic await_permit(input int lim, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		while (n < lim && !ok) begin
			@(posedge sys_clk);
			n++;
			ok = (start_release_permit === 1'b1);
			if (general_alarm === 1'b1) begin
				start_a <= 1'b0;
				start_b <= 1'b0;
				n = lim;
			end
		end
	endtask

	// Release start some cycles later
	task automatic let_go(input int lag);
		repeat (lag) @(posedge sys_clk);
		start_a <= 1'b0;
		start_b <= 1'b0;
	endtask

	// Short reset pulse
	task automatic pulse_reset();
		@(posedge sys_clk);
		ext_reset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ext_reset <= 1'b0;
	endtask

	// Reset line held at a level
	task automatic hold_reset(input logic v);
		@(posedge sys_clk);
		ext_reset <= v;
	endtask
endmodule

// >>> wch_props.sv
/*
 Checker for the welder cycle handshake pins.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module wch_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start_a,
	input wire logic start_b,
	input wire logic cycle_abort,
	input wire logic ready_n,
	input wire logic start_release_permit,
	input wire logic general_alarm,
	input wire logic horn_extend,
	input wire logic clear_out
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// Ready and start release never shown together
	ready_perm_a: assert property (
		!ready_n |-> !start_release_permit) else $error("permit while ready");
	// A cycle only begins from the ready state
	accept_ready_a: assert property (
		$rose(start_release_permit) |-> !$past(ready_n)) else $error("start taken while busy");
	// A cycle follows a start that is still held
	accept_start_a: assert property (
		$rose(start_release_permit) |-> $past(start_a, 3)) else $error("cycle without start");
	// A cycle needs a start that was low just before it rose
	start_fresh_a: assert property (
		$rose(start_release_permit) |-> (!$past(start_a, 4) || !$past(start_b, 4)))
		else $error("stale start taken");
	// Horn down only inside a permitted cycle
	extend_perm_a: assert property (
		horn_extend |-> start_release_permit) else $error("horn down without permit");
	// A pending alarm keeps ready off
	alarm_ready_a: assert property (
		general_alarm && $past(general_alarm) |-> ready_n) else $error("ready during alarm");
	// Abort keeps ready off
	abort_hold_a: assert property (
		cycle_abort [*6] |-> ready_n) else $error("ready during abort");
	// Abort retracts the horn
	abort_retract_a: assert property (
		cycle_abort [*6] |-> !horn_extend) else $error("horn down during abort");

	// Main scenarios reached
	cover property ($rose(start_release_permit));
	cover property ($rose(general_alarm));
	cover property ($rose(clear_out));
endmodule

bind wch_welder_handshake wch_props u_wch_props (.sys_clk, .nrst, .start_a, .start_b, .cycle_abort,
	.ready_n, .start_release_permit, .general_alarm, .horn_extend, .clear_out);

// >>> wch_regs.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 welder cycle handshake block. Assumes a 200 MHz system clock.
*/
`ifndef WCH_REGS_SVH
`define WCH_REGS_SVH

// Register byte offsets
`define WCH_OFS_CTRL       8'h00
`define WCH_OFS_CLEAR_DIST 8'h04
`define WCH_OFS_WELD_TIME  8'h08
`define WCH_OFS_HOLD_TIME  8'h0c
`define WCH_OFS_STATUS     8'h10
`define WCH_OFS_IRQ_STAT   8'h14
`define WCH_OFS_IRQ_MASK   8'h18

// Control fields
`define WCH_CTRL_STACK_ONLY 0
`define WCH_CTRL_CLEAR_EN   1
`define WCH_CTRL_DIST_SENSE 2
`define WCH_CTRL_PANEL_RST  3

// Interrupt status fields
`define WCH_IRQ_DONE    0
`define WCH_IRQ_ALARM   1
`define WCH_IRQ_HALT    2
`define WCH_IRQ_ABORT   3
`define WCH_IRQ_DISCARD 4
`define WCH_IRQ_W       5

// Reset values
`define WCH_RST_CTRL       32'h0000_0004
`define WCH_RST_CLEAR_DIST 32'h0000_0100
`define WCH_RST_WELD_TIME  32'h0003_0d40
`define WCH_RST_HOLD_TIME  32'h0003_0d40
`define WCH_RST_IRQ_MASK   32'h0000_0000

// Timing
`define WCH_CLK_KHZ        200000
`define WCH_CHECK_TIME_MS  100
`define WCH_CHECK_CYC      (`WCH_CHECK_TIME_MS * `WCH_CLK_KHZ)

`endif

// >>> wch_welder_handshake.sv
/*
 Welder cycle handshake: start acceptance, start release, alarm reset,
 abort and safety halt, single or dual start, horn clearance output,
 AXI4-Lite register slave and a level interrupt.
 Assumes pin inputs are asynchronous to sys_clk and a 200 MHz sys_clk.
*/
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "wch_regs.svh"

module wch_welder_handshake #(
	parameter logic [31:0] CHECK_CYC = 32'(`WCH_CHECK_CYC)
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        start_a,
	input  wire logic        start_b,
	input  wire logic        ext_reset,
	input  wire logic        cycle_abort,
	input  wire logic        safety_halt,
	input  wire logic        fault,
	input  wire logic        upper_limit,
	input  wire logic [15:0] horn_pos,
	output logic             ready_n,
	output logic             start_release_permit,
	output logic             general_alarm,
	output logic             clear_out,
	output logic             horn_extend,
	output logic             irq,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	localparam int NPIN = 7;
	localparam logic [NPIN-1:0] PIN_IDLE = 7'h40; // Upper limit rests high, no false edge

	wch_pkg::wch_state_t state;
	wch_pkg::wch_state_t next_state;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	logic [NPIN-1:0] pin_prev;
	logic [15:0]     pos_s1;
	logic [15:0]     pos_s2;
	logic [15:0]     weld_pos;
	logic [31:0]     cnt;
	logic [31:0]     ctrl;
	logic [31:0]     clear_dist;
	logic [31:0]     weld_time;
	logic [31:0]     hold_time;
	logic [`WCH_IRQ_W-1:0] irq_stat;
	logic [`WCH_IRQ_W-1:0] irq_mask;
	logic [`WCH_IRQ_W-1:0] irq_ev;
	logic            panel_rst;
	logic            start_a_s;
	logic            start_b_s;
	logic            reset_s;
	logic            abort_s;
	logic            halt_s;
	logic            fault_s;
	logic            upper_s;
	logic            start_cmd;
	logic            start_prev;
	logic            start_rise;
	logic            reset_ev;
	logic            ready_int;
	logic            start_acc;
	logic            end_cycle;
	logic            horn_clear;
	logic [7:0]      aw_addr;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;
	logic            aw_got;
	logic            w_got;
	logic            wr_fire;
	logic            wr_hit;
	logic [31:0]     rd_data;
	logic            rd_hit;

	// Pin vector for the synchronisers
	assign pin_raw = {upper_limit, fault, safety_halt, cycle_abort, ext_reset, start_b, start_a};

	// Two-flop synchroniser per pin
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					pin_s1[gi]   <= PIN_IDLE[gi];
					pin_s2[gi]   <= PIN_IDLE[gi];
					pin_prev[gi] <= PIN_IDLE[gi];
				end else begin
					pin_s1[gi]   <= pin_raw[gi];
					pin_s2[gi]   <= pin_s1[gi];
					pin_prev[gi] <= pin_s2[gi];
				end
			end
		end
	endgenerate

	// Position bus synchroniser, sensor assumed to change slowly
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pos_s1 <= 16'h0000;
			pos_s2 <= 16'h0000;
		end else begin
			pos_s1 <= horn_pos;
			pos_s2 <= pos_s1;
		end
	end

	assign start_a_s = pin_s2[0];
	assign start_b_s = pin_s2[1];
	assign reset_s   = pin_s2[2];
	assign abort_s   = pin_s2[3];
	assign halt_s    = pin_s2[4];
	assign fault_s   = pin_s2[5];
	assign upper_s   = pin_s2[6];

	// Start qualification: one or both inputs depending on mode
	assign start_cmd = ctrl[`WCH_CTRL_STACK_ONLY] ? start_a_s
	                                               : (start_a_s & start_b_s);

	// Edge tracking of the qualified start
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= start_cmd;
		end
	end

	// Only a fresh rising start counts, so a held start never queues
	assign start_rise = start_cmd & ~start_prev;
	assign ready_int  = (state == wch_pkg::WCH_ST_READY) & ~general_alarm & ~abort_s & ~halt_s;
	assign start_acc  = start_rise & ready_int;
	// Fresh external reset edge or panel reset pulse
	assign reset_ev   = (reset_s & ~pin_prev[2]) | panel_rst;
	assign end_cycle  = abort_s | (fault_s & ~pin_prev[5]);

	// Cycle sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			wch_pkg::WCH_ST_READY: begin
				if (halt_s) begin
					next_state = wch_pkg::WCH_ST_HALT;
				end else if (start_acc) begin
					next_state = wch_pkg::WCH_ST_WELD;
				end
			end
			wch_pkg::WCH_ST_WELD: begin
				if (halt_s) begin
					next_state = wch_pkg::WCH_ST_HALT;
				end else if (end_cycle) begin
					next_state = wch_pkg::WCH_ST_RETRACT;
				end else if (cnt == 32'h0000_0000) begin
					next_state = wch_pkg::WCH_ST_HOLD;
				end
			end
			wch_pkg::WCH_ST_HOLD: begin
				if (halt_s) begin
					next_state = wch_pkg::WCH_ST_HALT;
				end else if (end_cycle || cnt == 32'h0000_0000) begin
					next_state = wch_pkg::WCH_ST_RETRACT;
				end
			end
			wch_pkg::WCH_ST_RETRACT: begin
				if (halt_s) begin
					next_state = wch_pkg::WCH_ST_HALT;
				end else if (ctrl[`WCH_CTRL_STACK_ONLY] || upper_s) begin
					next_state = wch_pkg::WCH_ST_READY;
				end
			end
			wch_pkg::WCH_ST_HALT: begin
				if (reset_ev && !halt_s) begin
					next_state = wch_pkg::WCH_ST_CHECK;
				end
			end
			wch_pkg::WCH_ST_CHECK: begin
				if (halt_s) begin
					next_state = wch_pkg::WCH_ST_HALT;
				end else if (cnt == 32'h0000_0000) begin
					next_state = wch_pkg::WCH_ST_READY;
				end
			end
			default: begin
				next_state = wch_pkg::WCH_ST_READY;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= wch_pkg::WCH_ST_READY;
		end else begin
			state <= next_state;
		end
	end

	// Phase timer, loaded on each state change
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 32'h0000_0000;
		end else if (next_state != state) begin
			case (next_state)
				wch_pkg::WCH_ST_WELD:  cnt <= weld_time;
				wch_pkg::WCH_ST_HOLD:  cnt <= hold_time;
				wch_pkg::WCH_ST_CHECK: cnt <= CHECK_CYC;
				default:               cnt <= 32'h0000_0000;
			endcase
		end else if (cnt != 32'h0000_0000) begin
			cnt <= cnt - 32'h0000_0001;
		end
	end

	// General alarm: set by fault or halt, cleared only by a fresh reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			general_alarm <= 1'b0;
		end else if ((fault_s & ~pin_prev[5]) | halt_s) begin
			general_alarm <= 1'b1;
		end else if (reset_ev && general_alarm) begin
			general_alarm <= 1'b0;
		end
	end

	// Pin outputs from the next state, so ready and permit never overlap
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ready_n              <= 1'b1;
			start_release_permit <= 1'b0;
			horn_extend          <= 1'b0;
		end else begin
			ready_n              <= ~((next_state == wch_pkg::WCH_ST_READY) & ~general_alarm &
			                          ~abort_s & ~halt_s);
			start_release_permit <= (next_state == wch_pkg::WCH_ST_WELD) |
			                        (next_state == wch_pkg::WCH_ST_HOLD) |
			                        (next_state == wch_pkg::WCH_ST_RETRACT);
			horn_extend          <= (next_state == wch_pkg::WCH_ST_WELD) |
			                        (next_state == wch_pkg::WCH_ST_HOLD);
		end
	end

	// Position at the start of retraction
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			weld_pos <= 16'h0000;
		end else if (next_state == wch_pkg::WCH_ST_RETRACT && state != wch_pkg::WCH_ST_RETRACT) begin
			weld_pos <= pos_s2;
		end
	end

	assign horn_clear = (pos_s2 <= weld_pos) && ((weld_pos - pos_s2) >= clear_dist[15:0]);

	// Clearance output, cleared by each accepted start
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			clear_out <= 1'b0;
		end else if (start_acc || !ctrl[`WCH_CTRL_CLEAR_EN]) begin
			clear_out <= 1'b0;
		end else if (ctrl[`WCH_CTRL_DIST_SENSE]) begin
			if (state == wch_pkg::WCH_ST_RETRACT && horn_clear) begin
				clear_out <= 1'b1;
			end
		end else if (upper_s && !pin_prev[6]) begin
			clear_out <= ~clear_out;
		end
	end

	// Interrupt events
	assign irq_ev[`WCH_IRQ_DONE]    = (state == wch_pkg::WCH_ST_RETRACT) &
	                                  (next_state == wch_pkg::WCH_ST_READY);
	assign irq_ev[`WCH_IRQ_ALARM]   = fault_s & ~pin_prev[5];
	assign irq_ev[`WCH_IRQ_HALT]    = halt_s & ~pin_prev[4];
	assign irq_ev[`WCH_IRQ_ABORT]   = abort_s & ~pin_prev[3];
	assign irq_ev[`WCH_IRQ_DISCARD] = start_rise & ~ready_int;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Write address channel
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			aw_got        <= 1'b0;
			aw_addr       <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_got        <= 1'b1;
			aw_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_got        <= 1'b0;
		end
	end

	// Write data channel
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_wready <= 1'b1;
			w_got        <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_got        <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_got        <= 1'b0;
		end
	end

	assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
	assign wr_hit  = (aw_addr == `WCH_OFS_CTRL) | (aw_addr == `WCH_OFS_CLEAR_DIST) |
	                 (aw_addr == `WCH_OFS_WELD_TIME) | (aw_addr == `WCH_OFS_HOLD_TIME) |
	                 (aw_addr == `WCH_OFS_STATUS) | (aw_addr == `WCH_OFS_IRQ_STAT) |
	                 (aw_addr == `WCH_OFS_IRQ_MASK);

	// Write response, SLVERR for unmapped offsets
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl       <= `WCH_RST_CTRL;
			clear_dist <= `WCH_RST_CLEAR_DIST;
			weld_time  <= `WCH_RST_WELD_TIME;
			hold_time  <= `WCH_RST_HOLD_TIME;
			irq_mask   <= `WCH_IRQ_W'(`WCH_RST_IRQ_MASK);
		end else if (wr_fire) begin
			case (aw_addr)
				`WCH_OFS_CTRL:       ctrl       <= merge(ctrl, w_data, w_strb) & 32'h0000_0007;
				`WCH_OFS_CLEAR_DIST: clear_dist <= merge(clear_dist, w_data, w_strb) & 32'h0000_ffff;
				`WCH_OFS_WELD_TIME:  weld_time  <= merge(weld_time, w_data, w_strb);
				`WCH_OFS_HOLD_TIME:  hold_time  <= merge(hold_time, w_data, w_strb);
				`WCH_OFS_IRQ_MASK:   irq_mask   <= w_strb[0] ? w_data[`WCH_IRQ_W-1:0] : irq_mask;
				default:             ctrl       <= ctrl;
			endcase
		end
	end

	// Front panel reset: one-cycle pulse from a write of one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			panel_rst <= 1'b0;
		end else begin
			panel_rst <= wr_fire && aw_addr == `WCH_OFS_CTRL && w_strb[0] &&
			             w_data[`WCH_CTRL_PANEL_RST];
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat <= '0;
		end else if (wr_fire && aw_addr == `WCH_OFS_IRQ_STAT && w_strb[0]) begin
			irq_stat <= (irq_stat & ~w_data[`WCH_IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat <= irq_stat | irq_ev;
		end
	end

	// Interrupt line
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Read decode
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			`WCH_OFS_CTRL:       rd_data = ctrl;
			`WCH_OFS_CLEAR_DIST: rd_data = clear_dist;
			`WCH_OFS_WELD_TIME:  rd_data = weld_time;
			`WCH_OFS_HOLD_TIME:  rd_data = hold_time;
			`WCH_OFS_STATUS:     rd_data = {24'h0, state, horn_extend, clear_out,
			                                general_alarm, start_release_permit, ~ready_n};
			`WCH_OFS_IRQ_STAT:   rd_data = {27'h0, irq_stat};
			`WCH_OFS_IRQ_MASK:   rd_data = {27'h0, irq_mask};
			default:             rd_hit  = 1'b0;
		endcase
	end

	// Read channel, one outstanding read
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

endmodule
